// file: dv/test_skip_and_xor_literal_tb.sv
// bench: random test-skip and xor-literal slots against a bench model
module test_skip_and_xor_literal_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import tsx_pkg::*;
	logic       clk, rst, ext_set_en, flag_n, flag_z, flag_we, skip_active;
	logic [3:0] bank_select_reg;
	logic [7:0] rd_data, fsr2_low, work, w_exp;
	logic [1:0] q_phase;
	logic       n_exp, z_exp, run;
	tsx_instr_t instr;
	tsx_mem_t   mem;
	int         err_count, n_compared, cycles;
	tsx_core tsx_core_inst (.clk(clk), .rst(rst), .ext_set_en(ext_set_en),
		.bank_select_reg(bank_select_reg), .instr(instr), .rd_data(rd_data),
		.fsr2_low(fsr2_low), .mem(mem), .q_phase(q_phase), .work(work),
		.flag_n(flag_n), .flag_z(flag_z), .flag_we(flag_we),
		.skip_active(skip_active));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	task chk(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			wrap_up();
		end
	end
	// model of work and flags, checked every cycle
	always @(negedge clk) if (run) begin
		chk(12'(work), 12'(w_exp));
		chk(12'(flag_n), 12'(n_exp));
		chk(12'(flag_z), 12'(z_exp));
		if (skip_active === 1'b1) chk(12'(mem.rd_en), 12'h000);
	end
	task slot(input logic [15:0] w, input logic tw, input logic [7:0] rd);
		int          cnt;
		logic [31:0] cfg;
		logic        ix;
		cfg = $urandom;
		do @(negedge clk); while (q_phase !== TSX_Q_LAST || skip_active !== 1'b0);
		@(posedge clk);
		instr <= '{word: w, valid: 1'b1, two_word: tw};
		rd_data <= rd;
		ext_set_en <= cfg[0];
		bank_select_reg <= cfg[4:1];
		fsr2_low <= cfg[12:5];
		repeat (2) @(negedge clk);
		if (w[15:9] == TSX_OP_TEST_SKIP) begin
			ix = !w[8] && cfg[0] && w[7:0] <= TSX_INDEXED_MAX;
			chk(12'(mem.rd_en), 12'h001);
			chk(12'(mem.indexed), 12'(ix));
			if (ix) chk(12'(mem.addr[7:0]), 12'(8'(cfg[12:5] + w[7:0])));
			else if (w[8]) chk(mem.addr, {cfg[4:1], w[7:0]});
			else chk(mem.addr, {w[7:0] >= TSX_ACCESS_SPLIT ? TSX_ACCESS_HIGH
				: 4'h0, w[7:0]});
			repeat (2) @(negedge clk);
			@(posedge clk);
			instr <= '{word: {TSX_OP_TEST_SKIP, 1'b0, cfg[20:13]},
				valid: rd == 8'h00, two_word: tw};
			cnt = 0;
			repeat (10) begin
				@(negedge clk);
				cnt += int'(skip_active);
				if (cnt == 2) begin
					@(posedge clk);
					instr.valid <= 1'b0;
				end
			end
			chk(12'(cnt), 12'(rd != 8'h00 ? 0 : tw ? 8 : 4));
		end else begin
			repeat (2) @(negedge clk);
			@(posedge clk);
			instr.valid <= 1'b0;
			w_exp = w_exp ^ w[7:0];
			n_exp = w_exp[7];
			z_exp = w_exp == 8'h00;
			@(negedge clk);
			chk(12'(flag_we), 12'h001);
		end
	endtask : slot
	initial begin
		logic [31:0] r;
		logic [7:0]  f;
		void'($urandom(32'hC0B1820A));
		{rst, run, ext_set_en, rd_data, fsr2_low, bank_select_reg} = '0;
		rst = 1'b1;
		instr = '0;
		{w_exp, n_exp, z_exp} = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		run = 1'b1;
		for (int i = 0; i < 300; i++) begin
			r = $urandom;
			f = r[23:21] != 3'h0 ? r[9:2] : r[24] ? TSX_INDEXED_MAX : TSX_ACCESS_SPLIT;
			if (r[0]) slot({TSX_OP_TEST_SKIP, r[1], f}, r[10],
				r[11] ? 8'h00 : r[19:12]);
			else slot({TSX_OP_XOR_LIT, r[23:21] != 3'h0 ? r[9:2] : w_exp},
				1'b0, 8'h00);
		end
		wrap_up();
	end
endmodule : test_skip_and_xor_literal_tb

// file: logic/tsx_core.sv
// core slice: test-and-skip and xor-literal execute with q phases
// Summary of operation
// - match test-skip opcode, access bit, address
// - zero operand flushes next instruction, two cycles
// - skipping two-word instruction costs three cycles
// - access bit picks access bank or bank register
// - extended set: low access-bank addresses (access bit clear) use indexed offset
// - match xor-literal opcode, low byte literal
// - xor literal into working register
// - xor updates only negative and zero
module tsx_core
	import tsx_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// configuration
	input  wire logic        ext_set_en,
	input  wire logic [3:0]  bank_select_reg,
	// instruction fetch
	input  tsx_instr_t       instr,
	// data memory
	input  wire logic [7:0]  rd_data,
	input  wire logic [7:0]  fsr2_low,
	output tsx_mem_t         mem,
	// core state out
	output logic [1:0]       q_phase,
	output logic [7:0]       work,
	output logic             flag_n,
	output logic             flag_z,
	output logic             flag_we,
	output logic             skip_active
);
	typedef struct packed {
		tsx_state_t  st;
		logic [1:0]  q;
		logic [1:0]  flush_left;
		logic [7:0]  work;
		logic        n;
		logic        z;
		logic        flag_we;
		logic        skip;
		tsx_mem_t    mem;
		logic        test_pend;
	} tsx_core_state_t;

	tsx_core_state_t s;
	tsx_core_state_t next_s;
	tsx_dec_t        dec;
	logic [7:0]      xres;

	tsx_decode u_dec (
		.word (instr.word),
		.dec  (dec)
	);

	always_comb begin
		next_s = s;
		xres = s.work ^ dec.operand;
		next_s.q = s.q + 2'h1;
		next_s.flag_we = 1'b0;
		next_s.mem.rd_en = 1'b0;
		case (s.st)
			TSX_ST_IDLE: begin
				next_s.st = TSX_ST_RUN;
				next_s.q = TSX_Q_FIRST;
			end
			TSX_ST_RUN: begin
				if (instr.valid && dec.is_test && s.q == TSX_Q_FIRST) begin
					next_s.mem.rd_en = 1'b1;
					next_s.test_pend = 1'b1;
					if (!dec.access) begin
						if (ext_set_en && dec.operand <= TSX_INDEXED_MAX) begin
							next_s.mem.indexed = 1'b1;
							next_s.mem.addr = {4'h0, fsr2_low + dec.operand};
						end else begin
							next_s.mem.indexed = 1'b0;
							next_s.mem.addr = (dec.operand < TSX_ACCESS_SPLIT)
								? {4'h0, dec.operand}
								: {TSX_ACCESS_HIGH, dec.operand};
						end
					end else begin
						next_s.mem.indexed = 1'b0;
						next_s.mem.addr = {bank_select_reg, dec.operand};
					end
				end
				if (s.test_pend && s.q == 2'h2) begin
					next_s.test_pend = 1'b0;
					// flags and work untouched by the test
					if (rd_data == 8'h00) begin
						next_s.skip = 1'b1;
						next_s.flush_left = TSX_FLUSH_ONE;
					end
				end
				if (instr.valid && dec.is_xor && s.q == TSX_Q_LAST) begin
					next_s.work = xres;
					next_s.n = xres[7];
					next_s.z = (xres == 8'h00);
					next_s.flag_we = 1'b1;
				end
				if (s.skip && s.q == TSX_Q_LAST) begin
					next_s.st = TSX_ST_FLUSH;
				end
			end
			TSX_ST_FLUSH: begin
				// no write, flag update or memory access here
				next_s.mem.rd_en = 1'b0;
				if (s.q == TSX_Q_FIRST && s.flush_left == TSX_FLUSH_ONE
					&& instr.two_word) begin
					next_s.flush_left = TSX_FLUSH_TWO;
				end
				if (s.q == TSX_Q_LAST) begin
					if (s.flush_left == TSX_FLUSH_TWO) begin
						next_s.flush_left = TSX_FLUSH_NONE;
						next_s.skip = 1'b1;
					end else begin
						next_s.flush_left = TSX_FLUSH_NONE;
						next_s.skip = 1'b0;
						next_s.st = TSX_ST_RUN;
					end
				end
			end
			default: begin
				next_s.st = TSX_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '{st: TSX_ST_IDLE, q: TSX_Q_FIRST, flush_left: TSX_FLUSH_NONE,
				work: TSX_W_RESET, n: 1'b0, z: 1'b0, flag_we: 1'b0,
				skip: 1'b0, mem: '0, test_pend: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign mem         = s.mem;
	assign q_phase     = s.q;
	assign work        = s.work;
	assign flag_n      = s.n;
	assign flag_z      = s.z;
	assign flag_we     = s.flag_we;
	assign skip_active = (s.st == TSX_ST_FLUSH);

	flush_quiet_a: assert property (@(posedge clk) disable iff (rst)
		s.st == TSX_ST_FLUSH |-> !s.flag_we && !s.mem.rd_en
		&& $stable(s.work))
		else $error("activity during flushed slot");

	xor_result_a: assert property (@(posedge clk) disable iff (rst)
		s.st == TSX_ST_RUN && instr.valid && dec.is_xor
		&& s.q == TSX_Q_LAST |=> s.work == ($past(s.work) ^ $past(dec.operand)))
		else $error("xor result wrong");

	xor_flags_a: assert property (@(posedge clk) disable iff (rst)
		s.flag_we |-> s.n == s.work[7] && s.z == (s.work == 8'h00))
		else $error("xor flags wrong");

	test_keeps_a: assert property (@(posedge clk) disable iff (rst)
		s.test_pend && !(instr.valid && dec.is_xor) |=> $stable(s.work)
		&& $stable(s.n) && $stable(s.z))
		else $error("test changed state");

	skip_zero_a: assert property (@(posedge clk) disable iff (rst)
		s.test_pend && s.q == 2'h2 && rd_data == 8'h00
		|=> s.skip ##1 s.st == TSX_ST_FLUSH)
		else $error("zero did not skip");

	no_skip_a: assert property (@(posedge clk) disable iff (rst)
		s.test_pend && s.q == 2'h2 && rd_data != 8'h00 && !s.skip |=> !s.skip)
		else $error("nonzero skipped");

	flush_len_a: assert property (@(posedge clk) disable iff (rst)
		s.st == TSX_ST_FLUSH && s.flush_left == TSX_FLUSH_TWO
		&& s.q == TSX_Q_LAST |=> s.st == TSX_ST_FLUSH [*4])
		else $error("second flush cycle missing");

	bank_addr_a: assert property (@(posedge clk) disable iff (rst)
		s.st == TSX_ST_RUN && instr.valid && dec.is_test && dec.access
		&& s.q == TSX_Q_FIRST |=> s.mem.addr[11:8] == $past(bank_select_reg))
		else $error("bank bits wrong");

	indexed_a: assert property (@(posedge clk) disable iff (rst)
		s.mem.rd_en && s.mem.indexed |-> s.mem.addr[11:8] == 4'h0)
		else $error("indexed address out of range");

	test_read_a: assert property (@(posedge clk) disable iff (rst)
		s.st == TSX_ST_RUN && instr.valid && dec.is_test
		&& s.q == TSX_Q_FIRST |=> s.mem.rd_en && s.test_pend)
		else $error("test did not read");

	access_low_a: assert property (@(posedge clk) disable iff (rst)
		s.st == TSX_ST_RUN && instr.valid && dec.is_test
		&& !dec.access && !ext_set_en && s.q == TSX_Q_FIRST
		|=> !s.mem.indexed && s.mem.addr[7:0] == $past(dec.operand))
		else $error("access bank address wrong");

	indexed_pick_a: assert property (@(posedge clk) disable iff (rst)
		s.st == TSX_ST_RUN && instr.valid && dec.is_test
		&& !dec.access && ext_set_en && dec.operand <= TSX_INDEXED_MAX
		&& s.q == TSX_Q_FIRST |=> s.mem.indexed)
		else $error("indexed mode not chosen");

	flush_end_a: assert property (@(posedge clk) disable iff (rst)
		s.st == TSX_ST_FLUSH && s.flush_left != TSX_FLUSH_TWO
		&& s.q == TSX_Q_LAST |=> s.st == TSX_ST_RUN && !s.skip)
		else $error("flush did not end");

	two_word_a: assert property (@(posedge clk) disable iff (rst)
		s.st == TSX_ST_FLUSH && s.flush_left == TSX_FLUSH_ONE
		&& s.q == TSX_Q_FIRST && instr.two_word
		|=> s.flush_left == TSX_FLUSH_TWO)
		else $error("two-word flush not extended");

	flush_idle_a: assert property (@(posedge clk) disable iff (rst)
		s.st == TSX_ST_FLUSH |-> !s.test_pend)
		else $error("test pending in flushed slot");

	xor_phase_a: assert property (@(posedge clk) disable iff (rst)
		s.flag_we |-> s.q == TSX_Q_FIRST)
		else $error("xor write in wrong phase");
endmodule : tsx_core

// file: logic/tsx_decode.sv
// decoder: opcode match and operand split
module tsx_decode
	import tsx_pkg::*;
(
	// instruction in
	input  wire logic [15:0] word,
	// decoded fields
	output tsx_dec_t         dec
);
	always_comb begin
		dec.is_test = (word[15:9] == TSX_OP_TEST_SKIP);
		dec.is_xor  = (word[15:8] == TSX_OP_XOR_LIT);
		dec.access  = word[8];
		dec.operand = word[7:0];
	end
endmodule : tsx_decode

// file: logic/tsx_pkg.sv
// package: constants and carrier types for the skip and xor decoder
package tsx_pkg;
	localparam logic [6:0]  TSX_OP_TEST_SKIP = 7'h33;
	localparam logic [7:0]  TSX_OP_XOR_LIT   = 8'h0A;
	localparam logic [7:0]  TSX_INDEXED_MAX  = 8'h5F;
	localparam logic [7:0]  TSX_ACCESS_SPLIT = 8'h60;
	localparam logic [3:0]  TSX_ACCESS_HIGH  = 4'hF;
	localparam logic [7:0]  TSX_W_RESET      = 8'h00;
	localparam logic [1:0]  TSX_Q_LAST       = 2'h3;
	localparam logic [1:0]  TSX_Q_FIRST      = 2'h0;
	localparam logic [1:0]  TSX_FLUSH_ONE    = 2'h1;
	localparam logic [1:0]  TSX_FLUSH_TWO    = 2'h2;
	localparam logic [1:0]  TSX_FLUSH_NONE   = 2'h0;

	typedef enum logic [2:0] {
		TSX_ST_RUN   = 3'b001,
		TSX_ST_FLUSH = 3'b010,
		TSX_ST_IDLE  = 3'b100
	} tsx_state_t;

	typedef struct packed {
		logic [15:0] word;
		logic        valid;
		logic        two_word;
	} tsx_instr_t;

	typedef struct packed {
		logic        rd_en;
		logic [11:0] addr;
		logic        indexed;
	} tsx_mem_t;

	typedef struct packed {
		logic is_test;
		logic is_xor;
		logic access;
		logic [7:0] operand;
	} tsx_dec_t;
endpackage : tsx_pkg
